// File: hdl/stu_top.sv
// Serial target unit: SPI slave with DMA buffers and buffer semaphore
// How it works
// - All four clock modes, picked by polarity and phase inputs.
// - Disable leaves settings untouched; software need not rewrite them.
// - Transmit DMA reads RAM, receive DMA writes RAM, no CPU.
// - Receive limit above transmit limit: extra bytes send the fill char.
// - Done event only after DMA stops touching RAM.
// - Give-back while CPU does not hold semaphore does nothing.
// - Done-to-grant shortcut hands semaphore to CPU after each done.
// - Receive-full event when the receive buffer fills.
// - Surplus received bytes set a flag and are dropped.
// - Excess transmitted bytes set exhausted flag and send fill char.
// - At done, latch bytes sent from buffer and bytes written counters.
// - On enable the CPU owns the semaphore, with no grant event.
// - Request while CPU already holds it grants at once.
// - Select fall with CPU owner: ignore input, send unserved char.
// - Simultaneous CPU request and slave take: CPU wins.
// - Granted: store received bytes, send transmit buffer bytes.
// - Granted transaction ends at select high: release and done.
// - Without CPU claim, granted transactions run back to back.
// - Request during slave ownership is granted after release.
// - Shortcut plus request in transaction serves one request only.
// - MISO undriven whenever chip select is high.
// - Limits and counters hold up to a 13-bit maximum.
`timescale 1ns/1ps
module stu_top
	import stu_pkg::*;
#(
	parameter int COUNT_WIDTH = STU_COUNT_WIDTH
) (
	input  wire logic                      clock,
	input  wire logic                      reset_n,
	input  wire logic                      enable,
	input  wire logic                      clock_polarity,
	input  wire logic                      clock_phase,
	input  wire logic                      lsb_first,
	input  wire logic                      shortcut_done_grant,
	input  wire logic                      task_request,
	input  wire logic                      task_give_back,
	input  wire logic [7:0]                tx_exhausted_flag_fill_char,
	input  wire logic [7:0]                unserved_fill_char,
	input  wire logic [STU_ADDR_WIDTH-1:0] rx_buffer_pointer,
	input  wire logic [STU_ADDR_WIDTH-1:0] tx_buffer_pointer,
	input  wire logic [COUNT_WIDTH-1:0]    rx_buffer_limit,
	input  wire logic [COUNT_WIDTH-1:0]    tx_buffer_limit,
	input  wire logic                      spi_select_n,
	input  wire logic                      spi_clock,
	input  wire logic                      spi_mosi,
	output logic                           spi_miso_out,
	output logic                           spi_miso_oe_n,
	output logic                           dma_rd_req,
	output logic      [STU_ADDR_WIDTH-1:0] dma_rd_addr,
	input  wire logic                      dma_rd_ack,
	input  wire logic [7:0]                dma_rd_data,
	output logic                           dma_wr_req,
	output logic      [STU_ADDR_WIDTH-1:0] dma_wr_addr,
	output logic      [7:0]                dma_wr_data,
	input  wire logic                      dma_wr_ack,
	output logic                           event_granted,
	output logic                           event_done,
	output logic                           receive_buffer_full_event,
	output logic                           rx_surplus_flag,
	output logic                           tx_exhausted_flag,
	output logic      [COUNT_WIDTH-1:0]    rx_count_last,
	output logic      [COUNT_WIDTH-1:0]    tx_count_last,
	output logic                           semaphore_cpu,
	output logic                           semaphore_slave
);
	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		stu_sem_type            sem;
		logic                   pending;
		logic                   sel_q;
		logic                   sck_q;
		logic                   granted;
		logic                   ending;
		logic                   ready;
		logic [COUNT_WIDTH-1:0] rx_n;
		logic [COUNT_WIDTH-1:0] tx_n;
		logic [COUNT_WIDTH-1:0] fetch_n;
		logic                   tx_full;
		logic                   rd_busy;
		logic                   wr_busy;
		logic [7:0]             tx_byte;
		logic [7:0]             wr_data;
		logic                   granted_ev;
		logic                   done_ev;
		logic                   full_ev;
		logic                   surplus;
		logic                   exhausted;
		logic [COUNT_WIDTH-1:0] rx_last;
		logic [COUNT_WIDTH-1:0] tx_last;
	} stu_state_type;

	stu_state_type state;
	stu_state_type next_state;

	logic [2:0] pins_sync;
	logic       sel_n;
	logic       sck;
	logic       mosi;
	logic       rise;
	logic       fall;
	logic       lead;
	logic       trail;
	logic       sample_edge;
	logic       shift_edge;
	logic       load_req;
	logic       byte_done;
	logic [7:0] rx_byte;
	logic [7:0] load_byte;
	logic       miso_bit;

	initial begin
		if (COUNT_WIDTH < 1 || COUNT_WIDTH > STU_COUNT_WIDTH)
			$error("stu_top count width");
	end

	// ****************************************
	// Pin synchronisers
	// ****************************************
	stu_sync #(.WIDTH(3), .RESET_VALUE(3'h4)) u_sync (
		.clock       (clock),
		.reset_n     (reset_n),
		.pin_in      ({spi_select_n, spi_clock, spi_mosi}),
		.pin_sync    (pins_sync)
	);
	assign sel_n = pins_sync[2];
	assign sck   = pins_sync[1];
	assign mosi  = pins_sync[0];

	// ****************************************
	// Clock mode edges
	// ****************************************
	assign rise  = sck && !state.sck_q;
	assign fall  = !sck && state.sck_q;
	assign lead  = clock_polarity ? fall : rise;
	assign trail = clock_polarity ? rise : fall;
	assign sample_edge = clock_phase ? trail : lead;
	assign shift_edge  = clock_phase ? lead : trail;

	// Unserved char goes out for the whole ignored frame
	assign load_byte = !state.granted ? unserved_fill_char
	                 : state.tx_full ? state.tx_byte : tx_exhausted_flag_fill_char;

	stu_shift u_shift (
		.clock          (clock),
		.reset_n        (reset_n),
		.active         (!sel_n && state.ready && enable),
		.sample_edge    (sample_edge),
		.shift_edge     (shift_edge),
		.phase_trailing (clock_phase),
		.lsb_first      (lsb_first),
		.load_byte      (load_byte),
		.load_req       (load_req),
		.byte_done      (byte_done),
		.rx_byte        (rx_byte),
		.mosi_bit_in    (mosi),
		.miso_bit       (miso_bit)
	);

	// ****************************************
	// Semaphore, DMA and counters
	// ****************************************
	always_comb begin
		next_state            = state;
		next_state.granted_ev = 1'b0;
		next_state.done_ev    = 1'b0;
		next_state.full_ev    = 1'b0;
		next_state.sel_q      = sel_n;
		next_state.sck_q      = sck;
		// Shifter waits for the first fetch so MISO never starts stale
		next_state.ready      = !sel_n
		                        && (state.ready
		                        || (!state.sel_q && !state.rd_busy));
		if (!enable) begin
			next_state.ready   = 1'b0;
			next_state.tx_full = 1'b0;
			next_state.sem     = STU_SEM_OFF;
			next_state.pending = 1'b0;
			next_state.granted = 1'b0;
			next_state.ending  = 1'b0;
			next_state.rd_busy = 1'b0;
			next_state.wr_busy = 1'b0;
		end else begin
			if (state.sem == STU_SEM_OFF) begin
				next_state.sem = STU_SEM_CPU;
			end
			// Select fall: slave tries to take, CPU wins a tie
			if (!sel_n && state.sel_q) begin
				if (state.sem == STU_SEM_FREE && !task_request) begin
					next_state.sem       = STU_SEM_SLAVE;
					next_state.granted   = 1'b1;
					next_state.rx_n      = COUNT_WIDTH'(STU_COUNT_ZERO);
					next_state.tx_n      = COUNT_WIDTH'(STU_COUNT_ZERO);
					next_state.fetch_n   = COUNT_WIDTH'(STU_COUNT_ZERO);
					next_state.tx_full   = 1'b0;
					next_state.surplus   = 1'b0;
					next_state.exhausted = 1'b0;
					next_state.rd_busy   = tx_buffer_limit != '0;
				end else begin
					next_state.granted = 1'b0;
				end
			end
			unique case (state.sem)
				STU_SEM_OFF: begin
				end
				STU_SEM_CPU: begin
					if (task_request) begin
						next_state.granted_ev = 1'b1;
					end else if (task_give_back) begin
						next_state.sem = STU_SEM_FREE;
					end
				end
				STU_SEM_FREE: begin
					if (task_request) begin
						next_state.sem        = STU_SEM_CPU;
						next_state.granted_ev = 1'b1;
					end
					// Give-back here is ignored
				end
				STU_SEM_SLAVE: begin
					if (task_request) begin
						next_state.pending = 1'b1;
					end
					if (sel_n && !state.sel_q) begin
						next_state.ending = 1'b1;
					end
					// Done waits for both DMA channels to go quiet
					if (state.ending && !state.rd_busy && !state.wr_busy) begin
						next_state.ending  = 1'b0;
						next_state.granted = 1'b0;
						next_state.done_ev = 1'b1;
						next_state.rx_last = state.rx_n;
						next_state.tx_last = state.tx_n;
						next_state.pending = 1'b0;
						if (state.pending || task_request || shortcut_done_grant) begin
							next_state.sem        = STU_SEM_CPU;
							next_state.granted_ev = 1'b1;
						end else begin
							next_state.sem = STU_SEM_FREE;
						end
					end
				end
			endcase
			// Transmit channel: one byte held ahead of the shifter
			if (state.granted && load_req) begin
				next_state.tx_full = 1'b0;
			end
			if (state.granted && !state.ending && !sel_n && !state.rd_busy
			    && !state.tx_full && state.fetch_n < tx_buffer_limit) begin
				next_state.rd_busy = 1'b1;
			end
			if (state.rd_busy && dma_rd_ack) begin
				next_state.rd_busy = 1'b0;
				next_state.tx_byte = dma_rd_data;
				next_state.tx_full = 1'b1;
				next_state.fetch_n = state.fetch_n + COUNT_WIDTH'(STU_COUNT_ONE);
			end
			// Bytes counted when fully sent, so a spare prefetch is not
			if (state.granted && byte_done && !state.ending) begin
				if (state.tx_n < tx_buffer_limit) begin
					next_state.tx_n = state.tx_n + COUNT_WIDTH'(STU_COUNT_ONE);
				end else begin
					next_state.exhausted = 1'b1;
				end
			end
			// Receive channel: store or drop completed bytes
			if (state.granted && byte_done && !state.ending) begin
				if (state.rx_n < rx_buffer_limit) begin
					next_state.wr_busy = 1'b1;
					next_state.wr_data = rx_byte;
				end else begin
					next_state.surplus = 1'b1;
				end
			end
			if (state.wr_busy && dma_wr_ack) begin
				next_state.wr_busy = 1'b0;
				next_state.rx_n    = state.rx_n + COUNT_WIDTH'(STU_COUNT_ONE);
				if (state.rx_n + COUNT_WIDTH'(STU_COUNT_ONE) == rx_buffer_limit) begin
					next_state.full_ev = 1'b1;
				end
			end
		end
	end

	// Settings stay with the caller across disable; nothing here clears them
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state       <= '0;
			state.sel_q <= 1'b1;
		end else begin
			state <= next_state;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign spi_miso_out  = miso_bit;
	assign spi_miso_oe_n = sel_n || !enable;
	assign dma_rd_req    = state.rd_busy;
	assign dma_rd_addr   = tx_buffer_pointer + STU_ADDR_WIDTH'(state.fetch_n);
	assign dma_wr_req    = state.wr_busy;
	assign dma_wr_addr   = rx_buffer_pointer + STU_ADDR_WIDTH'(state.rx_n);
	assign dma_wr_data   = state.wr_data;
	assign event_granted = state.granted_ev;
	assign event_done    = state.done_ev;
	assign receive_buffer_full_event = state.full_ev;
	assign rx_surplus_flag   = state.surplus;
	assign tx_exhausted_flag = state.exhausted;
	assign rx_count_last     = state.rx_last;
	assign tx_count_last     = state.tx_last;
	assign semaphore_cpu     = state.sem == STU_SEM_CPU;
	assign semaphore_slave   = state.sem == STU_SEM_SLAVE;

	// ****************************************
	// Checks
	// ****************************************
	chk_no_initial_grant: assert property (@(posedge clock) disable iff (!reset_n)
		$past(state.sem) == STU_SEM_OFF |-> !event_granted)
		else $error("grant raised on enable");
	chk_request_cpu_grant: assert property (@(posedge clock) disable iff (!reset_n)
		enable && semaphore_cpu && task_request |=> event_granted)
		else $error("request while cpu owns not granted");
	chk_give_back_ignored: assert property (@(posedge clock) disable iff (!reset_n)
		enable && semaphore_slave && task_give_back && !(sel_n && !state.sel_q)
		&& !state.ending |=> semaphore_slave)
		else $error("give-back changed slave ownership");
	chk_miso_released: assert property (@(posedge clock) disable iff (!reset_n)
		sel_n |-> spi_miso_oe_n)
		else $error("miso driven while unselected");
	chk_done_dma_quiet: assert property (@(posedge clock) disable iff (!reset_n)
		event_done |-> !dma_rd_req && !dma_wr_req)
		else $error("done while dma active");
	chk_done_counts: assert property (@(posedge clock) disable iff (!reset_n)
		event_done |-> rx_count_last == $past(state.rx_n))
		else $error("receive count not latched");
	chk_done_tx_bound: assert property (@(posedge clock) disable iff (!reset_n)
		event_done |-> tx_count_last <= tx_buffer_limit)
		else $error("transmit count above limit");
	chk_fetch_in_limit: assert property (@(posedge clock) disable iff (!reset_n)
		dma_rd_req |-> state.fetch_n < tx_buffer_limit)
		else $error("fetch beyond transmit limit");
	chk_shortcut_grant: assert property (@(posedge clock) disable iff (!reset_n)
		event_done && $past(shortcut_done_grant) && $past(enable)
		|-> semaphore_cpu && event_granted)
		else $error("shortcut did not hand over");
	chk_unserved_drop: assert property (@(posedge clock) disable iff (!reset_n)
		!state.granted |-> !dma_wr_req ##1 !(dma_wr_req && $rose(dma_wr_req) && !state.granted))
		else $error("write while not granted");
endmodule // stu_top

// File: hdl/stu_pkg.sv
// Package: constants and types for the serial target unit
package stu_pkg;
	// ****************************************
	// Sizes and codes
	// ****************************************
	localparam int       STU_COUNT_WIDTH = 13;
	localparam int       STU_ADDR_WIDTH  = 32;
	localparam int       STU_BYTE_BITS   = 8;
	localparam int       STU_BIT_WIDTH   = 3;
	localparam int       STU_SYNC_STAGES = 2;
	localparam bit [12:0] STU_COUNT_MAX  = 13'h1fff;
	localparam bit [2:0] STU_LAST_BIT    = 3'h7;
	localparam bit [2:0] STU_FIRST_BIT   = 3'h0;
	localparam bit [7:0] STU_BYTE_ZERO   = 8'h00;
	localparam bit [12:0] STU_COUNT_ZERO = 13'h0000;
	localparam bit [12:0] STU_COUNT_ONE  = 13'h0001;

	// ****************************************
	// Semaphore owner
	// ****************************************
	typedef enum logic [1:0] {
		STU_SEM_OFF,
		STU_SEM_CPU,
		STU_SEM_FREE,
		STU_SEM_SLAVE
	} stu_sem_type;
endpackage

// File: hdl/stu_sync.sv
// Two-stage synchroniser for pin level inputs
`timescale 1ns/1ps
module stu_sync
	import stu_pkg::*;
#(
	parameter int               WIDTH       = 3,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
	input  wire logic             clock,
	input  wire logic             reset_n,
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] pin_sync
);
	typedef struct packed {
		logic [WIDTH-1:0] first;
		logic [WIDTH-1:0] second;
	} stu_sync_type;

	stu_sync_type state;
	stu_sync_type next_state;

	initial begin
		if (WIDTH < 1) $error("stu_sync width");
	end

	always_comb begin
		next_state        = state;
		next_state.first  = pin_in;
		next_state.second = state.first;
	end

	// First stage feeds only the second stage
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			// Idle pin levels, so no false edge follows reset
			state <= '{first: RESET_VALUE, second: RESET_VALUE};
		end else begin
			state <= next_state;
		end
	end

	assign pin_sync = state.second;
endmodule // stu_sync

// File: hdl/stu_shift.sv
// Serial bit engine: samples MOSI and shifts MISO for one byte lane
`timescale 1ns/1ps
module stu_shift
	import stu_pkg::*;
(
	input  wire logic       clock,
	input  wire logic       reset_n,
	input  wire logic       active,
	input  wire logic       sample_edge,
	input  wire logic       shift_edge,
	input  wire logic       phase_trailing,
	input  wire logic       lsb_first,
	input  wire logic [7:0] load_byte,
	output logic            load_req,
	output logic            byte_done,
	output logic      [7:0] rx_byte,
	input  wire logic       mosi_bit_in,
	output logic            miso_bit
);
	typedef struct packed {
		logic [7:0] tx_shift;
		logic [7:0] rx_shift;
		logic [7:0] rx;
		logic [2:0] rx_count;
		logic [2:0] tx_count;
		logic       done;
		logic       primed;
		logic       miso;
	} stu_shift_type;

	stu_shift_type state;
	stu_shift_type next_state;
	logic [7:0]    next_rx;
	logic          out_event;
	logic          take;

	function automatic logic out_bit(input logic [7:0] b, input logic lsb);
		out_bit = lsb ? b[0] : b[7];
	endfunction

	function automatic logic [7:0] drop_bit(input logic [7:0] b,
		input logic lsb);
		drop_bit = lsb ? {1'b0, b[7:1]} : {b[6:0], 1'b0};
	endfunction

	assign load_req = take;

	always_comb begin
		next_state      = state;
		next_state.done = 1'b0;
		take            = 1'b0;
		next_rx         = lsb_first ? {mosi_bit_in, state.rx_shift[7:1]}
		                            : {state.rx_shift[6:0], mosi_bit_in};
		// Leading-sample modes need the first bit out before any edge
		out_event       = shift_edge || (!phase_trailing && !state.primed);
		if (!active) begin
			next_state.primed   = 1'b0;
			next_state.rx_count = STU_FIRST_BIT;
			next_state.tx_count = STU_FIRST_BIT;
		end else begin
			next_state.primed = 1'b1;
			if (out_event) begin
				next_state.tx_count = state.tx_count + 3'h1;
				if (state.tx_count == STU_FIRST_BIT) begin
					take                = 1'b1;
					next_state.miso     = out_bit(load_byte, lsb_first);
					next_state.tx_shift = drop_bit(load_byte, lsb_first);
				end else begin
					next_state.miso     = out_bit(state.tx_shift, lsb_first);
					next_state.tx_shift = drop_bit(state.tx_shift, lsb_first);
				end
			end
			if (sample_edge) begin
				next_state.rx_shift = next_rx;
				next_state.rx_count = state.rx_count + 3'h1;
				if (state.rx_count == STU_LAST_BIT) begin
					next_state.done = 1'b1;
					next_state.rx   = next_rx;
				end
			end
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign byte_done = state.done;
	assign rx_byte   = state.rx;
	assign miso_bit  = state.miso;
endmodule // stu_shift

// File: tb/stu_master.sv
// SPI master model for the serial target unit
`timescale 1ns/1ps
module stu_master (
	output logic      spi_select_n,
	output logic      spi_clock,
	output logic      spi_mosi,
	input  wire logic spi_miso_out,
	input  wire logic spi_miso_oe_n
);
	logic miso_last;
	logic miso;
	// Released line shows the inverse of its last level, never a stale copy
	assign miso = spi_miso_oe_n ? ~miso_last : spi_miso_out;
	always @(spi_miso_out or spi_miso_oe_n) begin
		if (!spi_miso_oe_n)
			miso_last = spi_miso_out;
	end
	initial begin
		spi_select_n = 1;
		spi_clock = 0;
		spi_mosi = 0;
		miso_last = 0;
	end
	// ****
	// One frame; clock stands still outside it
	// ****
	task automatic frame(input bit pol, input bit pha, input bit lsb,
		input logic [7:0] tx[$], output logic [7:0] rx[$]);
		logic [7:0] b;
		int         k;
		rx = {};
		#7 spi_clock = pol;
		#200 spi_select_n = 0;
		#2000;
		foreach (tx[i]) begin
			for (int j = 0; j < 8; j++) begin
				k = lsb ? j : 7 - j;
				if (!pha)
					spi_mosi = tx[i][k];
				#80 if (!pha)
					b[k] = miso;
				spi_clock = ~pol;
				if (pha)
					spi_mosi = tx[i][k];
				#80 if (pha)
					b[k] = miso;
				spi_clock = pol;
			end
			rx.push_back(b);
		end
		#400 spi_select_n = 1;
		spi_mosi = ~spi_mosi;
		#1000;
	endtask
endmodule // stu_master

// File: tb/stu_top_bench.sv
// Self-checking bench for the serial target unit
`timescale 1ns/1ps
module stu_top_bench;
	import stu_pkg::*;
	// ****
	// Signals
	// ****
	logic        clock = 0;
	logic        reset_n = 0;
	logic        enable = 0;
	logic        clock_polarity = 0;
	logic        clock_phase = 0;
	logic        lsb_first = 0;
	logic        shortcut_done_grant = 0;
	logic        task_request = 0;
	logic        task_give_back = 0;
	logic [7:0]  tx_exhausted_flag_fill_char = 8'h5a;
	logic [7:0]  unserved_fill_char = 8'ha5;
	logic [31:0] rx_buffer_pointer = 32'h00000080;
	logic [31:0] tx_buffer_pointer = 32'h00000010;
	logic [12:0] rx_buffer_limit = 13'h0003;
	logic [12:0] tx_buffer_limit = 13'h0003;
	logic        spi_select_n, spi_clock, spi_mosi;
	logic        spi_miso_out, spi_miso_oe_n;
	logic        dma_rd_req, dma_wr_req;
	logic        dma_rd_ack = 0;
	logic        dma_wr_ack = 0;
	logic [31:0] dma_rd_addr, dma_wr_addr;
	logic [7:0]  dma_rd_data = 8'h00;
	logic [7:0]  dma_wr_data;
	logic        event_granted, event_done, receive_buffer_full_event;
	logic        rx_surplus_flag, tx_exhausted_flag;
	logic        semaphore_cpu, semaphore_slave;
	logic [12:0] rx_count_last, tx_count_last;
	logic [7:0]  mem [256];
	logic [39:0] wq [$];
	int          n_errors = 0;
	int          n_tests = 0;
	int          n_grant = 0;
	int          n_done = 0;
	int          n_full = 0;
	int          done_wq = 0;
	// Receive limit, transmit limit, bytes in frame
	int          lim [4][3] = '{'{3, 3, 3}, '{2, 6, 4}, '{6, 2, 5}, '{4, 0, 2}};

	always #10 clock = ~clock;

	stu_top i_stu_top (
		.clock, .reset_n, .enable, .clock_polarity, .clock_phase, .lsb_first,
		.shortcut_done_grant, .task_request, .task_give_back,
		.tx_exhausted_flag_fill_char, .unserved_fill_char, .rx_buffer_pointer,
		.tx_buffer_pointer, .rx_buffer_limit, .tx_buffer_limit, .spi_select_n,
		.spi_clock, .spi_mosi, .spi_miso_out, .spi_miso_oe_n, .dma_rd_req,
		.dma_rd_addr, .dma_rd_ack, .dma_rd_data, .dma_wr_req, .dma_wr_addr,
		.dma_wr_data, .dma_wr_ack, .event_granted, .event_done,
		.receive_buffer_full_event, .rx_surplus_flag, .tx_exhausted_flag,
		.rx_count_last, .tx_count_last, .semaphore_cpu, .semaphore_slave
	);
	stu_master i_stu_master (
		.spi_select_n, .spi_clock, .spi_mosi, .spi_miso_out, .spi_miso_oe_n
	);

	// RAM model; random stalls keep the fetch path honest
	always @(negedge clock) begin
		dma_rd_ack <= dma_rd_req & ~dma_rd_ack & ($urandom % 3 != 0);
		dma_rd_data <= mem[dma_rd_addr[7:0]];
		dma_wr_ack <= dma_wr_req & ~dma_wr_ack & ($urandom % 3 != 0);
	end
	always @(posedge clock) begin
		if (event_granted)
			n_grant++;
		if (receive_buffer_full_event)
			n_full++;
		if (dma_wr_req && dma_wr_ack)
			wq.push_back({dma_wr_addr, dma_wr_data});
		if (event_done) begin
			n_done++;
			done_wq = wq.size();
			check(dma_rd_req | dma_wr_req, 0);
		end
	end

	// ****
	// Tasks
	// ****
	task automatic check(input logic [39:0] got, input logic [39:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic pulse(ref logic s);
		s = 1;
		@(negedge clock);
		s = 0;
	endtask

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic frame(input int n, input bit gr);
		logic [7:0] tx[$];
		logic [7:0] rx[$];
		logic [7:0] e;
		int         d0, f0, nr, nt, r, t;
		r = int'(rx_buffer_limit);
		t = int'(tx_buffer_limit);
		nr = n < r ? n : r;
		nt = n < t ? n : t;
		d0 = n_done;
		f0 = n_full;
		wq = {};
		for (int i = 0; i < n; i++)
			tx.push_back(8'($urandom));
		check(spi_miso_oe_n, 1);
		i_stu_master.frame(clock_polarity, clock_phase, lsb_first, tx, rx);
		for (int w = 0; gr && n_done == d0; w++) begin
			if (w == 400) begin
				n_errors++;
				$display("ERROR %0t: no done event", $time);
				complete_run();
			end
			@(negedge clock);
		end
		repeat (3) @(negedge clock);
		check(spi_miso_oe_n, 1);
		foreach (rx[i]) begin
			e = i >= t ? tx_exhausted_flag_fill_char : mem[8'(tx_buffer_pointer + i)];
			check(rx[i], gr ? e : unserved_fill_char);
		end
		check(wq.size(), gr ? nr : 0);
		foreach (wq[i])
			check(wq[i], {rx_buffer_pointer + i, tx[i]});
		check(n_done - d0, gr);
		if (gr) begin
			check(done_wq, nr);
			check(rx_count_last, nr);
			check(tx_count_last == nt || tx_count_last == (n < t ? n + 1 : t), 1);
			check(rx_surplus_flag, n > r);
			check(tx_exhausted_flag, n > t);
			check(n_full - f0, n >= r);
		end
	endtask

	initial begin
		void'($urandom(33618));
		foreach (mem[i])
			mem[i] = 8'($urandom);
		repeat (20) @(negedge clock);
		reset_n = 1;
		@(negedge clock);
		enable = 1;
		repeat (3) @(negedge clock);
		check(semaphore_cpu, 1);
		check(n_grant, 0);
		pulse(task_request);
		@(negedge clock);
		check(n_grant, 1);
		pulse(task_give_back);
		@(negedge clock);
		check(semaphore_cpu, 0);
		$display("test semaphore done");
		for (int m = 0; m < 4; m++) begin
			{clock_polarity, clock_phase} = 2'(m);
			lsb_first = m[0] ^ m[1];
			tx_exhausted_flag_fill_char = 8'($urandom);
			foreach (lim[k]) begin
				rx_buffer_limit = 13'(lim[k][0]);
				tx_buffer_limit = 13'(lim[k][1]);
				frame(lim[k][2], 1);
			end
		end
		$display("test modes done");
		rx_buffer_limit = STU_COUNT_MAX;
		tx_buffer_limit = STU_COUNT_MAX;
		fork
			frame(3, 1);
			begin
				#3000 @(negedge clock);
				pulse(task_give_back);
				pulse(task_request);
				@(negedge clock);
				check(semaphore_slave, 1);
				check(n_grant, 1);
			end
		join
		check(n_grant, 2);
		check(semaphore_cpu, 1);
		pulse(task_give_back);
		$display("test deferred grant done");
		shortcut_done_grant = 1;
		fork
			frame(3, 1);
			begin
				#3000 @(negedge clock);
				pulse(task_request);
			end
		join
		check(n_grant, 3);
		pulse(task_give_back);
		frame(2, 1);
		check(n_grant, 4);
		check(semaphore_cpu, 1);
		$display("test shortcut done");
		unserved_fill_char = 8'($urandom);
		fork
			frame(3, 0);
			begin
				#3000 @(negedge clock);
				pulse(task_give_back);
			end
		join
		shortcut_done_grant = 0;
		frame(2, 1);
		$display("test ungranted done");
		enable = 0;
		repeat (3) @(negedge clock);
		enable = 1;
		repeat (3) @(negedge clock);
		check(semaphore_cpu, 1);
		check(n_grant, 4);
		pulse(task_give_back);
		frame(3, 1);
		$display("test re-enable done");
		complete_run();
	end
endmodule // stu_top_bench
